//--- tb/adoc_capture.sv
// Capture logic latching the output word on the data ready clock
`timescale 1ns/100ps
module adoc_capture #(
  parameter real TD = 2.0
) (
  input wire polarity,
  input wire [13:0] word_pin,
  input wire flag_pin,
  input wire ready_pin,
  output logic [13:0] got_word = 14'h0000,
  output logic got_flag = 1'b0
);
  // Latch on the selected edge, delayed past output switching
  always @(ready_pin) begin
    if (ready_pin === !polarity) begin
      #TD;
      got_word = word_pin;
      got_flag = flag_pin;
    end
  end
endmodule

//--- tb/adoc_chk_sva.sv
// Checker on the output pins of the converter output control
`timescale 1ns/100ps
module adoc_chk #(
  parameter SLOW_CYC = 50
) (
  input wire CLK,
  input wire SYS_RST,
  input wire SAMPLE_CLK,
  input wire OUT_ENABLE,
  input wire [13:0] SAMPLE_WORD,
  input wire [13:0] SAMPLE_WORD_OE,
  input wire OUT_OF_RANGE_FLAG,
  input wire OUT_OF_RANGE_FLAG_OE,
  input wire DATA_READY_CLOCK,
  input wire DATA_READY_CLOCK_OE,
  input wire POWERED_DOWN
);
  logic sc_ff;
  logic [7:0] still_ff;
  wire [13:0] w = SAMPLE_WORD;
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the sample clock last moved
  always @(posedge CLK) begin
    sc_ff <= SAMPLE_CLK;
    if (SYS_RST || SAMPLE_CLK != sc_ff) still_ff <= 8'h00;
    else if (still_ff != 8'hFF) still_ff <= still_ff + 8'h01;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////////////////////
  oe_same_a: assert property (
    SAMPLE_WORD_OE == {14{DATA_READY_CLOCK_OE}}
    && OUT_OF_RANGE_FLAG_OE == DATA_READY_CLOCK_OE) else $error("oe split");
  oe_off_a: assert property (!OUT_ENABLE [*4] |-> !DATA_READY_CLOCK_OE)
    else $error("driven while disabled");
  reset_clear_a: assert property (disable iff (1'b0) SYS_RST
    |=> w == 14'h0000 && !OUT_OF_RANGE_FLAG && !DATA_READY_CLOCK_OE)
    else $error("reset state");
  flag_limit_a: assert property (OUT_OF_RANGE_FLAG |->
    w == 14'h3FFF || w == 14'h0000 || w == 14'h1FFF || w == 14'h2000)
    else $error("flag off limit");
  word_edge_a: assert property ($changed(w) |-> $changed(DATA_READY_CLOCK))
    else $error("word moved without ready clock");
  word_hold_a: assert property ($changed(w) |=> $stable(w) [*8])
    else $error("word not held");
  ready_hold_a: assert property (
    $changed(DATA_READY_CLOCK) |=>
    ($stable(DATA_READY_CLOCK) || POWERED_DOWN) [*3])
    else $error("ready clock glitch");
  slow_down_a: assert property (still_ff > SLOW_CYC + 6 |-> POWERED_DOWN)
    else $error("slow clock not detected");
  down_hold_a: assert property (POWERED_DOWN [*2] |-> $stable(w))
    else $error("update while down");
  cover property ($rose(OUT_OF_RANGE_FLAG));
  cover property ($rose(POWERED_DOWN));
  cover property ($fell(DATA_READY_CLOCK_OE));
endmodule
bind adoc_top adoc_chk #(.SLOW_CYC(SLOW_CYC)) u_chk (.*);

//--- tb/adoc_top_tb.sv
// Testbench of the converter output control
`timescale 1ns/100ps
module adoc_top_tb;
  typedef struct packed {
    logic [1:0] s;
    logic [1:0] pn;
    logic [13:0] c, w;
    logic f;
  } adoc_row_t;
  logic CLK = 0, SYS_RST = 1, SAMPLE_CLK = 0, OUT_ENABLE = 0, run = 1;
  logic CORE_OVER_POS = 0, CORE_OVER_NEG = 0, S_AXI_AWVALID = 0;
  logic S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
  logic S_AXI_RREADY = 0;
  logic [13:0] CORE_CODE = 14'h0000;
  logic [1:0] FORMAT_POLARITY_STRAP = 2'h0;
  logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h00000000;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  wire [13:0] SAMPLE_WORD, SAMPLE_WORD_OE, word_pin, got_word;
  wire OUT_OF_RANGE_FLAG, OUT_OF_RANGE_FLAG_OE, DATA_READY_CLOCK;
  wire DATA_READY_CLOCK_OE, POWERED_DOWN, DLL_OFF, IRQ, got_flag;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  wire S_AXI_RVALID;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  int n_errors = 0, n_compared = 0;
  logic [1:0] bresp_seen = 2'h0;
  adoc_row_t rows [8] = '{
    {2'h0, 2'b00, 14'h1234, 14'h1234, 1'b0},
    {2'h1, 2'b00, 14'h1234, 14'h3234, 1'b0},
    {2'h2, 2'b10, 14'h0100, 14'h3FFF, 1'b1},
    {2'h3, 2'b10, 14'h0100, 14'h1FFF, 1'b1},
    {2'h0, 2'b01, 14'h0100, 14'h0000, 1'b1},
    {2'h1, 2'b01, 14'h0100, 14'h2000, 1'b1},
    {2'h2, 2'b00, 14'h3FFF, 14'h3FFF, 1'b1},
    {2'h0, 2'b00, 14'h1234, 14'h1234, 1'b0}};
  assign word_pin = SAMPLE_WORD_OE[0] ? SAMPLE_WORD : 14'hzzzz;
  adoc_top #(.SLOW_CYC(40)) i_dut (.*);
  adoc_capture i_cap (.polarity(FORMAT_POLARITY_STRAP[1]),
    .word_pin(word_pin), .flag_pin(OUT_OF_RANGE_FLAG),
    .ready_pin(DATA_READY_CLOCK), .got_word(got_word), .got_flag(got_flag));
  initial forever #5 CLK = ~CLK;
  initial begin
    #3;
    forever #80 if (run) SAMPLE_CLK = ~SAMPLE_CLK;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1;
    S_AXI_WVALID <= 1;
    S_AXI_BREADY <= 1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 0;
    end while (!S_AXI_BVALID);
    bresp_seen = S_AXI_BRESP;
    S_AXI_BREADY <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1;
    S_AXI_RREADY <= 1;
    do begin
      @(posedge CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
    end while (!S_AXI_RVALID);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_errors++;
    test_done;
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    repeat (8) @(posedge CLK);
    chk("word", SAMPLE_WORD, 0);
    chk("oe", SAMPLE_WORD_OE, 0);
    SYS_RST <= 0;
    OUT_ENABLE <= 1;
    wr(8'h08, 1);
    chk("bresp", bresp_seen, 0);
    foreach (rows[i]) begin
      @(posedge CLK);
      FORMAT_POLARITY_STRAP <= rows[i].s;
      {CORE_OVER_POS, CORE_OVER_NEG} <= rows[i].pn;
      CORE_CODE <= rows[i].c;
      repeat (384) @(posedge CLK);
      chk("word", got_word, rows[i].w);
      chk("flag", got_flag, rows[i].f);
    end
    chk("irq", IRQ, 1);
    wr(8'h08, 0);
    chk("irq masked", IRQ, 0);
    wr(8'h08, 1);
    rd(8'h04, d, r);
    chk("stat", d[0], 1);
    repeat (2) @(posedge CLK);
    chk("irq cleared", IRQ, 0);
    rd(8'h0C, d, r);
    chk("word reg", d[14:0], 15'h1234);
    rd(8'h10, d, r);
    chk("resp", r, 3);
    wr(8'h10, 0);
    chk("bresp", bresp_seen, 3);
    OUT_ENABLE <= 0;
    repeat (4) @(posedge CLK);
    chk("oe", SAMPLE_WORD_OE, 0);
    chk("pin", word_pin === 14'hzzzz, 1);
    OUT_ENABLE <= 1;
    wr(8'h00, 1);
    chk("pdn", POWERED_DOWN, 1);
    chk("pdn oe", DATA_READY_CLOCK_OE, 0);
    wr(8'h00, 2);
    chk("dll", DLL_OFF, 1);
    run = 0;
    repeat (80) @(posedge CLK);
    chk("slow", POWERED_DOWN, 1);
    rd(8'h04, d, r);
    chk("slow ev", d[1], 1);
    run = 1;
    repeat (800) @(posedge CLK);
    chk("resume", POWERED_DOWN, 0);
    @(posedge SAMPLE_CLK);
    @(posedge CLK);
    CORE_CODE <= 14'h0AAA;
    n = 0;
    while (SAMPLE_WORD !== 14'h0AAA && n < 400) begin
      @(posedge CLK);
      n++;
    end
    chk("latency", n > 284 && n < 298, 1);
    SYS_RST <= 1;
    repeat (2) @(posedge CLK);
    chk("rst word", SAMPLE_WORD, 0);
    chk("rst dll", DLL_OFF, 0);
    SYS_RST <= 0;
    rd(8'h00, d, r);
    chk("rst ctrl", d, 0);
    chk("rst pdn", POWERED_DOWN, 0);
    test_done;
  end
endmodule

//--- verilog/adoc_map.vh
// Register offsets, field positions and timing constants of the output control
`ifndef ADOC_MAP_VH
`define ADOC_MAP_VH
`define ADOC_REG_CTRL 8'h00
`define ADOC_REG_STAT 8'h04
`define ADOC_REG_MASK 8'h08
`define ADOC_REG_WORD 8'h0C
`define ADOC_CTRL_PDN 0
`define ADOC_CTRL_DLL_OFF 1
`define ADOC_CTRL_RST 2'h0
`define ADOC_MASK_RST 2'h0
`define ADOC_EV_OVR 0
`define ADOC_EV_SLOW 1
`define ADOC_POS_OB 14'h3FFF
`define ADOC_POS_TC 14'h1FFF
`define ADOC_NEG_OB 14'h0000
`define ADOC_NEG_TC 14'h2000
`define ADOC_MSB_FLIP 14'h2000
`define ADOC_LAT_HALF 6'h23
`define ADOC_SLOW_NS 500
`define ADOC_CLK_NS 10
`define ADOC_RST_US 2
`define ADOC_RESP_OKAY 2'h0
`define ADOC_RESP_DECERR 2'h3
`endif

//--- verilog/adoc_top.v
// Digital output control of a 14-bit pipeline converter with AXI4-Lite registers
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
// Behaviour
// RULE_01: Each sample leaves as a 14-bit word, msb on top output, lsb bottom.
// RULE_02: Out-of-range flag is one whenever word sits at either full-scale limit.
// RULE_03: Two strap bits pick offset binary or two's complement and clock polarity.
// RULE_04: Outputs driven while output enable is high, released when it is low.
// RULE_05: Positive overdrive gives 3FFF offset binary or 1FFF two's complement.
// RULE_06: Negative overdrive gives 0000 offset binary or 2000 two's complement.
// RULE_07: Software power-down bit releases outputs; only reference kept running.
// RULE_08: Sample clock absent or below 2 MSPS may put the device in power-down; code powers down only after 500 ns without an edge, i.e. below 1 MSPS.
// RULE_09: Controller must select DLL-off mode before running below 60 MSPS.
// RULE_10: Capture logic using sample clock delays it by tD for setup and hold.
// RULE_11: Each conversion starts on the falling edge of the sample clock.
// RULE_12: A sample reaches the outputs 17.5 sample clock cycles after sampling.
// RULE_13: Reset pulse of 2 us clears registers, converter and drives outputs low; code releases the outputs while reset is high.
// RULE_14: Word and flag update once per sample; ready clock toggles per sample.
`include "adoc_map.vh"
module adoc_top #(
  parameter SLOW_CYC = `ADOC_SLOW_NS / `ADOC_CLK_NS,
  parameter DEPTH = 64
) (
  input wire CLK,
  input wire SYS_RST,
  input wire SAMPLE_CLK,
  input wire [13:0] CORE_CODE,
  input wire CORE_OVER_POS,
  input wire CORE_OVER_NEG,
  input wire [1:0] FORMAT_POLARITY_STRAP,
  input wire OUT_ENABLE,
  output wire [13:0] SAMPLE_WORD,
  output wire [13:0] SAMPLE_WORD_OE,
  output wire OUT_OF_RANGE_FLAG,
  output wire OUT_OF_RANGE_FLAG_OE,
  output wire DATA_READY_CLOCK,
  output wire DATA_READY_CLOCK_OE,
  output wire POWERED_DOWN,
  output wire DLL_OFF,
  output wire IRQ,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers
reg [2:0] sclk_ff;
reg [13:0] code_s1_ff;
reg [13:0] code_s2_ff;
reg [1:0] ovr_s1_ff;
reg [1:0] ovr_s2_ff;
reg [1:0] dfs_s1_ff;
reg [1:0] dfs_s2_ff;
reg [1:0] oe_sync_ff;
wire sclk_fall;
wire sclk_rise;

always @(posedge CLK) begin
  if (SYS_RST) begin
    sclk_ff <= 3'h0;
    code_s1_ff <= 14'h0000;
    code_s2_ff <= 14'h0000;
    ovr_s1_ff <= 2'h0;
    ovr_s2_ff <= 2'h0;
    dfs_s1_ff <= 2'h0;
    dfs_s2_ff <= 2'h0;
    oe_sync_ff <= 2'h0;
  end else begin
    sclk_ff <= {sclk_ff[1:0], SAMPLE_CLK};
    code_s1_ff <= CORE_CODE;
    code_s2_ff <= code_s1_ff;
    ovr_s1_ff <= {CORE_OVER_NEG, CORE_OVER_POS};
    ovr_s2_ff <= ovr_s1_ff;
    dfs_s1_ff <= FORMAT_POLARITY_STRAP;
    dfs_s2_ff <= dfs_s1_ff;
    oe_sync_ff <= {oe_sync_ff[0], OUT_ENABLE};
  end
end

assign sclk_fall = sclk_ff[2] & ~sclk_ff[1];
assign sclk_rise = ~sclk_ff[2] & sclk_ff[1];

////////////////////////////////////////////////////////////////////////////////
// Control registers
reg pdn_ff;
reg dll_off_ff;
reg [1:0] stat_ff;
reg [1:0] mask_ff;
reg [13:0] word_ff;
reg ovr_ff;
reg drdy_ff;
reg slow_ff;

////////////////////////////////////////////////////////////////////////////////
// Sample clock watchdog
reg [15:0] idle_cnt_ff;
wire [15:0] nxt_idle_cnt;

assign nxt_idle_cnt = (sclk_fall | sclk_rise) ? 16'h0000 :
  ((idle_cnt_ff == SLOW_CYC[15:0]) ? idle_cnt_ff : idle_cnt_ff + 16'h0001);

always @(posedge CLK) begin
  if (SYS_RST) begin
    idle_cnt_ff <= 16'h0000;
    slow_ff <= 1'b0;
  end else begin
    idle_cnt_ff <= nxt_idle_cnt;
    slow_ff <= (nxt_idle_cnt == SLOW_CYC[15:0]); // RULE_08
  end
end

////////////////////////////////////////////////////////////////////////////////
// Coding and overdrive
reg [13:0] coded;

always @* begin
  if (ovr_s2_ff[0]) begin
    coded = dfs_s2_ff[0] ? `ADOC_POS_TC : `ADOC_POS_OB; // RULE_05
  end else if (ovr_s2_ff[1]) begin
    coded = dfs_s2_ff[0] ? `ADOC_NEG_TC : `ADOC_NEG_OB; // RULE_06
  end else if (dfs_s2_ff[0]) begin
    coded = code_s2_ff ^ `ADOC_MSB_FLIP; // RULE_03
  end else begin
    coded = code_s2_ff;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Pipeline of half sample clock cycles
reg [13:0] pipe_code_ff [0:DEPTH-1];
reg [DEPTH-1:0] pipe_ovr_ff;
reg [5:0] half_cnt_ff;
wire half_step;

assign half_step = sclk_fall | sclk_rise; // RULE_12

genvar gi;
generate
  for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_pipe
    if (gi == 0) begin : g_head
      // First stage takes a sample on each synced falling edge
      always @(posedge CLK) begin
        if (SYS_RST) begin
          pipe_code_ff[gi] <= 14'h0000;
          pipe_ovr_ff[gi] <= 1'b0;
        end else if (sclk_fall) begin
          pipe_code_ff[gi] <= coded; // RULE_11
          pipe_ovr_ff[gi] <= (ovr_s2_ff != 2'h0);
        end
      end
    end else begin : g_tail
      // Later stages move on every half sample clock cycle
      always @(posedge CLK) begin
        if (SYS_RST) begin
          pipe_code_ff[gi] <= 14'h0000;
          pipe_ovr_ff[gi] <= 1'b0;
        end else if (half_step) begin
          pipe_code_ff[gi] <= pipe_code_ff[gi-1];
          pipe_ovr_ff[gi] <= pipe_ovr_ff[gi-1];
        end
      end
    end
  end
endgenerate

always @(posedge CLK) begin
  if (SYS_RST) begin
    half_cnt_ff <= 6'h00;
  end else if (half_step && half_cnt_ff != `ADOC_LAT_HALF) begin
    half_cnt_ff <= half_cnt_ff + 6'h01;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Output word, flag and ready clock
wire [13:0] lat_code;
wire lat_ovr;
wire at_limit;

assign lat_code = pipe_code_ff[`ADOC_LAT_HALF - 6'h01];
assign lat_ovr = pipe_ovr_ff[`ADOC_LAT_HALF - 6'h01];
assign at_limit = dfs_s2_ff[0] ?
  (lat_code == `ADOC_POS_TC || lat_code == `ADOC_NEG_TC) :
  (lat_code == `ADOC_POS_OB || lat_code == `ADOC_NEG_OB);

always @(posedge CLK) begin
  if (SYS_RST) begin
    word_ff <= 14'h0000; // RULE_13
    ovr_ff <= 1'b0;
    drdy_ff <= 1'b0;
  end else if (slow_ff || pdn_ff) begin
    drdy_ff <= dfs_s2_ff[1];
  end else if (sclk_rise && half_cnt_ff == `ADOC_LAT_HALF) begin
    word_ff <= lat_code; // RULE_01
    ovr_ff <= lat_ovr | at_limit; // RULE_02
    drdy_ff <= ~dfs_s2_ff[1]; // RULE_14
  end else if (sclk_fall) begin
    drdy_ff <= dfs_s2_ff[1]; // RULE_03
  end
end

wire drive_en;

assign drive_en = oe_sync_ff[1] & ~pdn_ff; // RULE_04 RULE_07
assign SAMPLE_WORD = word_ff;
assign SAMPLE_WORD_OE = {14{drive_en}};
assign OUT_OF_RANGE_FLAG = ovr_ff;
assign OUT_OF_RANGE_FLAG_OE = drive_en;
assign DATA_READY_CLOCK = drdy_ff;
assign DATA_READY_CLOCK_OE = drive_en;
assign POWERED_DOWN = pdn_ff | slow_ff; // RULE_08
assign DLL_OFF = dll_off_ff; // RULE_09

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave
reg aw_got_ff;
reg w_got_ff;
reg [7:0] awaddr_ff;
reg [31:0] wdata_ff;
reg [3:0] wstrb_ff;
reg bvalid_ff;
reg [1:0] bresp_ff;
reg rvalid_ff;
reg [31:0] rdata_ff;
reg [1:0] rresp_ff;
wire do_write;
wire do_read;
wire stat_rd;
wire [1:0] ev;

assign S_AXI_AWREADY = ~aw_got_ff & ~bvalid_ff;
assign S_AXI_WREADY = ~w_got_ff & ~bvalid_ff;
assign do_write = aw_got_ff & w_got_ff & ~bvalid_ff;
assign S_AXI_ARREADY = ~rvalid_ff;
assign do_read = S_AXI_ARVALID & ~rvalid_ff;
assign stat_rd = do_read && S_AXI_ARADDR == `ADOC_REG_STAT;
assign ev[`ADOC_EV_OVR] = sclk_rise && half_cnt_ff == `ADOC_LAT_HALF &&
  (lat_ovr | at_limit) && !slow_ff && !pdn_ff;
assign ev[`ADOC_EV_SLOW] = slow_ff;

always @(posedge CLK) begin
  if (SYS_RST) begin
    aw_got_ff <= 1'b0;
    w_got_ff <= 1'b0;
    awaddr_ff <= 8'h00;
    wdata_ff <= 32'h00000000;
    wstrb_ff <= 4'h0;
    bvalid_ff <= 1'b0;
    bresp_ff <= `ADOC_RESP_OKAY;
    {dll_off_ff, pdn_ff} <= `ADOC_CTRL_RST; // RULE_13
    mask_ff <= `ADOC_MASK_RST;
  end else begin
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_ff <= 1'b1;
      awaddr_ff <= S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_ff <= 1'b1;
      wdata_ff <= S_AXI_WDATA;
      wstrb_ff <= S_AXI_WSTRB;
    end
    if (do_write) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b1;
      bresp_ff <= `ADOC_RESP_OKAY;
      if (awaddr_ff == `ADOC_REG_CTRL) begin
        if (wstrb_ff[0]) begin
          pdn_ff <= wdata_ff[`ADOC_CTRL_PDN]; // RULE_07
          dll_off_ff <= wdata_ff[`ADOC_CTRL_DLL_OFF];
        end
      end else if (awaddr_ff == `ADOC_REG_MASK) begin
        if (wstrb_ff[0]) begin
          mask_ff <= wdata_ff[1:0];
        end
      end else if (awaddr_ff != `ADOC_REG_STAT &&
          awaddr_ff != `ADOC_REG_WORD) begin
        bresp_ff <= `ADOC_RESP_DECERR;
      end
    end else if (bvalid_ff && S_AXI_BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end
end

always @(posedge CLK) begin
  if (SYS_RST) begin
    rvalid_ff <= 1'b0;
    rdata_ff <= 32'h00000000;
    rresp_ff <= `ADOC_RESP_OKAY;
    stat_ff <= 2'h0;
  end else begin
    stat_ff <= (stat_rd ? 2'h0 : stat_ff) | ev;
    if (do_read) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= `ADOC_RESP_OKAY;
      case (S_AXI_ARADDR)
        `ADOC_REG_CTRL: begin
          rdata_ff <= {30'h00000000, dll_off_ff, pdn_ff};
        end
        `ADOC_REG_STAT: begin
          rdata_ff <= {30'h00000000, stat_ff};
        end
        `ADOC_REG_MASK: begin
          rdata_ff <= {30'h00000000, mask_ff};
        end
        `ADOC_REG_WORD: begin
          rdata_ff <= {17'h00000, ovr_ff, word_ff};
        end
        default: begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= `ADOC_RESP_DECERR;
        end
      endcase
    end else if (rvalid_ff && S_AXI_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end
end

assign S_AXI_BVALID = bvalid_ff;
assign S_AXI_BRESP = bresp_ff;
assign S_AXI_RVALID = rvalid_ff;
assign S_AXI_RDATA = rdata_ff;
assign S_AXI_RRESP = rresp_ff;
assign IRQ = |(stat_ff & mask_ff);

endmodule
